// ### verilog/adc_control_and_mux_select.sv
// control logic of a 10-bit converter: selection, start, flag, prescaler
// assumes a wishbone classic master on clk_i and an analog core on the same clock
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps

module adc_control_and_mux_select
  import adc_ctrl_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [9:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [TRIG_W-1:0]   trigger_i,
  input  wire logic                global_irq_enable_i,
  input  wire logic                irq_vector_ack_i,
  input  wire logic [RESULT_W-1:0] conv_result_i,
  output core_req_t                conv_o,
  output logic                     done_irq_req_o,
  output logic                     irq_o
);

  // trigger pins come from outside: two flip-flops first
  logic [TRIG_W-1:0] trig_meta_q;
  logic [TRIG_W-1:0] trig_sync_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_meta_q <= '0;
      trig_sync_q <= '0;
    end else begin
      trig_meta_q <= trigger_i;
      trig_sync_q <= trig_meta_q;
    end
  end

  // register state
  logic                enable_q, enable_d;
  logic                auto_trig_q, auto_trig_d;
  logic                flag_q, flag_d;
  logic                irq_en_q, irq_en_d;
  logic [2:0]          div_sel_q, div_sel_d;
  logic [1:0]          ref_sel_q, ref_sel_d;
  logic                left_align_q, left_align_d;
  logic [4:0]          chan_sel_q, chan_sel_d;
  logic [2:0]          trig_sel_q, trig_sel_d;
  logic [IRQ_BITS-1:0] irq_stat_q, irq_stat_d;
  logic [IRQ_BITS-1:0] irq_mask_q, irq_mask_d;
  // conversion state
  logic                busy_q, busy_d;
  logic                init_due_q, init_due_d;
  logic [4:0]          cyc_left_q, cyc_left_d;
  logic [6:0]          div_cnt_q, div_cnt_d;
  logic [RESULT_W-1:0] result_q, result_d;
  logic                locked_q, locked_d;
  logic                trig_prev_q, trig_prev_d;
  // bus and outputs
  logic                ack_q, ack_d;
  logic [31:0]         rdata_q, rdata_d;
  core_req_t           conv_q, conv_d;
  logic                done_req_q, done_req_d;
  logic                irq_q, irq_d;

  // combinational helpers
  logic                bus_req;
  logic                wr_lo;
  logic                rd;
  logic [7:0]          idx;
  logic [7:0]          wbyte;
  logic [7:0]          div_last;
  logic                conv_tick;
  logic                complete;
  logic                abort;
  logic                trig_level;
  logic                trig_edge;
  logic                start_req;
  logic [15:0]         presented;
  logic [7:0]          rbyte;
  logic                sw_start;
  logic                sw_clear_flag;
  logic [2:0]          div_shift;

  always_comb begin
    bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    idx       = wb_adr_i[9:2];
    wbyte     = wb_dat_i[7:0];
    wr_lo     = bus_req & wb_we_i & wb_sel_i[0];
    rd        = bus_req & ~wb_we_i;

    // codes 000 and 001 both give two, then doubling
    div_shift = (div_sel_q == 3'h0) ? 3'h1 : div_sel_q;
    div_last  = 8'((9'h001 << div_shift) - 9'h001);
    // a count left above a smaller new divider ends the period at once, no wrap
    conv_tick = enable_q & (div_cnt_q >= div_last[6:0]);

    complete  = busy_q & conv_tick & (cyc_left_q == 5'd1);
    sw_start  = wr_lo & (idx == IDX_CTRL_A) & wbyte[CA_START];
    sw_clear_flag = wr_lo & (idx == IDX_CTRL_A) & wbyte[CA_DONE_FLAG];

    // selected source only when not free running; a switch of source may edge
    trig_level = (trig_sel_q == TRIG_FREE_RUN) ? 1'b0 : trig_sync_q[trig_sel_q];
    trig_edge  = auto_trig_q & trig_level & ~trig_prev_q;

    // right or left justified view, recomputed every read
    presented = left_align_q ? {result_q, 6'h00} : {6'h00, result_q};
  end

  always_comb begin
    enable_d     = enable_q;
    auto_trig_d  = auto_trig_q;
    irq_en_d     = irq_en_q;
    div_sel_d    = div_sel_q;
    ref_sel_d    = ref_sel_q;
    left_align_d = left_align_q;
    chan_sel_d   = chan_sel_q;
    trig_sel_d   = trig_sel_q;
    irq_mask_d   = irq_mask_q;
    locked_d     = locked_q;

    if (wr_lo) begin
      if (idx == IDX_CTRL_A) begin
        enable_d    = wbyte[CA_ENABLE];
        auto_trig_d = wbyte[CA_AUTO_TRIG];
        irq_en_d    = wbyte[CA_IRQ_ENABLE];
        div_sel_d   = wbyte[CA_DIV_MSB:0];
      end else if (idx == IDX_INPUT_SEL) begin
        ref_sel_d    = wbyte[IS_REF_MSB:IS_REF_LSB];
        left_align_d = wbyte[IS_LEFT_ALIGN];
        chan_sel_d   = wbyte[IS_SEL_MSB:0];
      end else if (idx == IDX_TRIG_SEL) begin
        trig_sel_d = wbyte[2:0];
      end else if (idx == IDX_IRQ_MASK) begin
        irq_mask_d = wbyte[IRQ_BITS-1:0];
      end
    end

    // low byte read freezes the result pair until the high byte is read
    if (rd && idx == IDX_RESULT_LOW) begin
      locked_d = 1'b1;
    end else if (rd && idx == IDX_RESULT_HIGH) begin
      locked_d = 1'b0;
    end

    abort = busy_q & ~enable_d;

    // start: software one, trigger edge, or free-running restart; zero writes ignored
    start_req = enable_d & ~busy_q &
                (sw_start | trig_edge);
    if (complete && auto_trig_q && trig_sel_q == TRIG_FREE_RUN && enable_d) begin
      start_req = 1'b1;
    end

    // prescaler runs only while enabled
    if (!enable_d) begin
      div_cnt_d = 7'h00;
    end else if (conv_tick) begin
      div_cnt_d = 7'h00;
    end else begin
      div_cnt_d = 7'(div_cnt_q + 7'h01);
    end

    // initialisation owed on every off-to-on transition
    init_due_d = init_due_q;
    if (!enable_d) begin
      init_due_d = 1'b0;
    end else if (!enable_q) begin
      init_due_d = 1'b1;
    end

    busy_d     = busy_q;
    cyc_left_d = cyc_left_q;
    if (abort) begin
      busy_d = 1'b0;
    end else if (start_req) begin
      busy_d     = 1'b1;
      cyc_left_d = init_due_d ? CONV_CYCLES_FIRST : CONV_CYCLES_NORMAL;
      init_due_d = 1'b0;
    end else if (complete) begin
      busy_d = 1'b0;
    end else if (busy_q && conv_tick) begin
      cyc_left_d = 5'(cyc_left_q - 5'd1);
    end

    result_d = result_q;
    if (complete && !locked_d) begin
      result_d = conv_result_i;
    end

    // hardware set wins over vector or software clear
    flag_d = complete | (flag_q & ~(sw_clear_flag | irq_vector_ack_i));

    // sticky status, write one to clear, event wins
    irq_stat_d = irq_stat_q;
    if (wr_lo && idx == IDX_IRQ_STATUS) begin
      irq_stat_d = irq_stat_q & ~wbyte[IRQ_BITS-1:0];
    end
    irq_stat_d[IRQ_BIT_DONE]  = irq_stat_d[IRQ_BIT_DONE] | complete;
    irq_stat_d[IRQ_BIT_ABORT] = irq_stat_d[IRQ_BIT_ABORT] | abort;

    irq_d      = |(irq_stat_d & irq_mask_d);
    done_req_d = flag_d & irq_en_d & global_irq_enable_i;

    trig_prev_d = trig_level;
  end

  // select reaches the core only between conversions or at completion
  always_comb begin
    conv_d                     = conv_q;
    conv_d.enable              = enable_d;
    conv_d.start               = start_req;
    conv_d.done                = complete;
    // code decoding to inputs, pairs and gain lives in the analog core
    if (!busy_q || complete) begin
      conv_d.channel_gain_select = chan_sel_d;
    end
  end

  // bus answer: one cycle after the request, unmapped reads give zero
  always_comb begin
    rbyte = 8'h00;
    if (idx == IDX_CTRL_A) begin
      rbyte = {enable_q, busy_q, auto_trig_q, flag_q, irq_en_q, div_sel_q};
    end else if (idx == IDX_INPUT_SEL) begin
      rbyte = {ref_sel_q, left_align_q, chan_sel_q};
    end else if (idx == IDX_TRIG_SEL) begin
      rbyte = {5'h00, trig_sel_q};
    end else if (idx == IDX_RESULT_LOW) begin
      rbyte = presented[7:0];
    end else if (idx == IDX_RESULT_HIGH) begin
      rbyte = presented[15:8];
    end else if (idx == IDX_IRQ_STATUS) begin
      rbyte = {6'h00, irq_stat_q};
    end else if (idx == IDX_IRQ_MASK) begin
      rbyte = {6'h00, irq_mask_q};
    end
    ack_d   = bus_req;
    rdata_d = rd ? {24'h000000, rbyte} : 32'h00000000;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_q     <= CTRL_A_RESET[CA_ENABLE];
      auto_trig_q  <= CTRL_A_RESET[CA_AUTO_TRIG];
      flag_q       <= CTRL_A_RESET[CA_DONE_FLAG];
      irq_en_q     <= CTRL_A_RESET[CA_IRQ_ENABLE];
      div_sel_q    <= CTRL_A_RESET[CA_DIV_MSB:0];
      ref_sel_q    <= INPUT_SEL_RESET[IS_REF_MSB:IS_REF_LSB];
      left_align_q <= INPUT_SEL_RESET[IS_LEFT_ALIGN];
      chan_sel_q   <= INPUT_SEL_RESET[IS_SEL_MSB:0];
      trig_sel_q   <= TRIG_FREE_RUN;
      irq_stat_q   <= '0;
      irq_mask_q   <= '0;
      busy_q       <= 1'b0;
      init_due_q   <= 1'b0;
      cyc_left_q   <= 5'd0;
      div_cnt_q    <= 7'h00;
      result_q     <= '0;
      locked_q     <= 1'b0;
      trig_prev_q  <= 1'b0;
      ack_q        <= 1'b0;
      rdata_q      <= 32'h00000000;
      conv_q       <= '0;
      done_req_q   <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      enable_q     <= enable_d;
      auto_trig_q  <= auto_trig_d;
      flag_q       <= flag_d;
      irq_en_q     <= irq_en_d;
      div_sel_q    <= div_sel_d;
      ref_sel_q    <= ref_sel_d;
      left_align_q <= left_align_d;
      chan_sel_q   <= chan_sel_d;
      trig_sel_q   <= trig_sel_d;
      irq_stat_q   <= irq_stat_d;
      irq_mask_q   <= irq_mask_d;
      busy_q       <= busy_d;
      init_due_q   <= init_due_d;
      cyc_left_q   <= cyc_left_d;
      div_cnt_q    <= div_cnt_d;
      result_q     <= result_d;
      locked_q     <= locked_d;
      trig_prev_q  <= trig_prev_d;
      ack_q        <= ack_d;
      rdata_q      <= rdata_d;
      conv_q       <= conv_d;
      done_req_q   <= done_req_d;
      irq_q        <= irq_d;
    end
  end

  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = rdata_q;
  assign conv_o         = conv_q;
  assign done_irq_req_o = done_req_q;
  assign irq_o          = irq_q;

endmodule : adc_control_and_mux_select

// ### verilog/adc_ctrl_pkg.sv
// package for the converter control block: register map, fields, timing
// assumes a classic wishbone slave with byte addresses of four times the index
package adc_ctrl_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CTRL_A      = 8'h7A;
  localparam logic [7:0] IDX_TRIG_SEL    = 8'h7B;
  localparam logic [7:0] IDX_INPUT_SEL   = 8'h7C;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h80;
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h81;

  // conversion_control_status_a fields
  localparam int CA_ENABLE     = 7;
  localparam int CA_START      = 6;
  localparam int CA_AUTO_TRIG  = 5;
  localparam int CA_DONE_FLAG  = 4;
  localparam int CA_IRQ_ENABLE = 3;
  localparam int CA_DIV_MSB    = 2;

  // input_select_and_align fields
  localparam int IS_REF_MSB    = 7;
  localparam int IS_REF_LSB    = 6;
  localparam int IS_LEFT_ALIGN = 5;
  localparam int IS_SEL_MSB    = 4;

  // interrupt status and mask layout
  localparam int IRQ_BIT_DONE  = 0;
  localparam int IRQ_BIT_ABORT = 1;
  localparam int IRQ_BITS      = 2;

  localparam logic [7:0] CTRL_A_RESET    = 8'h00;
  localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
  localparam logic [2:0] TRIG_FREE_RUN   = 3'h0;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] CONV_CYCLES_FIRST  = 5'd25;
  localparam logic [4:0] CONV_CYCLES_NORMAL = 5'd13;

  localparam int RESULT_W = 10;
  localparam int TRIG_W   = 8;

  // request to the analog conversion core
  typedef struct packed {
    logic       enable;
    logic       start;
    logic       done;
    logic [4:0] channel_gain_select;
  } core_req_t;

endpackage : adc_ctrl_pkg

// ### testbench/adc_ctrl_assertions.sv
// checker: bus answer, conversion pulses and interrupt gating at the ports
// assumes it is bound to the converter control block, one clock domain
`timescale 1ns/1ps
module adc_ctrl_assertions
  import adc_ctrl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        global_irq_enable_i,
  input wire core_req_t   conv_o,
  input wire logic        done_irq_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence conv_begin_s;
    conv_o.start;
  endsequence
  sequence conv_quiet_s;
    !conv_o.done [*8];
  endsequence
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside answer");
  start_pulse_a: assert property (conv_begin_s |=> !conv_o.start)
    else $error("start pulse too long");
  conv_length_a: assert property (conv_begin_s |=> conv_quiet_s)
    else $error("conversion ended too early");
  sel_hold_a: assert property (conv_begin_s |=> $stable(conv_o.channel_gain_select) [*8])
    else $error("select changed mid conversion");
  start_enabled_a: assert property (conv_o.start |-> conv_o.enable)
    else $error("start while disabled");
  done_pulse_a: assert property (conv_o.done |=> !conv_o.done)
    else $error("done pulse too long");
  irq_global_a: assert property (done_irq_req_o |-> $past(global_irq_enable_i))
    else $error("request without global enable");
endmodule : adc_ctrl_assertions

bind adc_control_and_mux_select adc_ctrl_assertions u_chk (.clk_i, .rst_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .global_irq_enable_i, .conv_o, .done_irq_req_o);

// ### testbench/adc_control_and_mux_select_tb.sv
// testbench: registers, conversion timing, result view, interrupts, triggers
// assumes the block answers each bus request one cycle after taking it
`timescale 1ns/1ps
module adc_control_and_mux_select_tb;
  import adc_ctrl_pkg::*;
  typedef struct packed { logic [7:0] ctrl; int cyc; } row_t;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, dreq, irq, gie = 1'b0, vack = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [9:0]  res = 10'h270;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0]  trig = 8'h00, q;
  core_req_t   conv;
  int          failures = 0, n_checks = 0, cycles = 0, n;
  // first row runs right after enabling, so it owes the long start-up
  row_t rows [9] = '{'{8'hD0, 50}, '{8'hD0, 26}, '{8'hD1, 26}, '{8'hD2, 52},
    '{8'hD3, 104}, '{8'hD4, 208}, '{8'hD5, 416}, '{8'hD6, 832}, '{8'hD7, 1664}};
  always #2.5 clk_i = ~clk_i;
  adc_control_and_mux_select u_dut (.clk_i, .rst_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .trigger_i(trig), .global_irq_enable_i(gie),
    .irq_vector_ack_i(vack), .conv_result_i(res), .conv_o(conv),
    .done_irq_req_o(dreq), .irq_o(irq));
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_near(input int got, input int exp, input int tol);
    n_checks++;
    if (got > exp + tol || got < exp - tol) begin
      failures++;
      $display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_near
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat[7:0];
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask : rd
  task automatic wait_done;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (conv.done !== 1'b1);
  endtask : wait_done
  // bit 4 set in every start write clears a stale flag first
  task automatic run(input logic [7:0] c, input int exp);
    wb(1'b1, IDX_CTRL_A, c);
    rd(IDX_CTRL_A, (c | 8'h40) & 8'hEF);
    wait_done;
    chk_near(n + 4, exp, exp / 13 + 3);
    rd(IDX_CTRL_A, c & 8'hBF);
  endtask : run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(IDX_CTRL_A, 8'h00);
    rd(IDX_INPUT_SEL, 8'h00);
    rd(8'h10, 8'h00);
    foreach (rows[i]) run(rows[i].ctrl, rows[i].cyc);
    wb(1'b1, IDX_CTRL_A, 8'hD7);
    rd(IDX_RESULT_LOW, 8'h70);
    rd(IDX_RESULT_HIGH, 8'h02);
    wb(1'b1, IDX_INPUT_SEL, 8'h20);
    rd(IDX_RESULT_LOW, 8'h00);
    res <= 10'h155;
    wait_done;
    rd(IDX_RESULT_HIGH, 8'h9C);
    run(8'hD0, 26);
    rd(IDX_RESULT_LOW, 8'h40);
    rd(IDX_RESULT_HIGH, 8'h55);
    for (int i = 0; i < 32; i++) begin
      wb(1'b1, IDX_INPUT_SEL, 8'(i));
      @(posedge clk_i);
      chk({3'h0, conv.channel_gain_select}, 8'(i));
    end
    wb(1'b1, IDX_CTRL_A, 8'hD7);
    wb(1'b1, IDX_INPUT_SEL, 8'h05);
    @(posedge clk_i);
    chk({3'h0, conv.channel_gain_select}, 8'h1F);
    wait_done;
    @(posedge clk_i);
    chk({3'h0, conv.channel_gain_select}, 8'h05);
    gie <= 1'b1;
    wb(1'b1, IDX_IRQ_MASK, 8'h01);
    run(8'hD8, 26);
    chk({6'h0, dreq, irq}, 8'h03);
    @(posedge clk_i);
    vack <= 1'b1;
    @(posedge clk_i);
    vack <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({7'h0, dreq}, 8'h00);
    rd(IDX_CTRL_A, 8'h88);
    wb(1'b1, IDX_IRQ_STATUS, 8'h03);
    @(posedge clk_i);
    chk({7'h0, irq}, 8'h00);
    gie <= 1'b0;
    run(8'hD8, 26);
    chk({7'h0, dreq}, 8'h00);
    wb(1'b1, IDX_IRQ_STATUS, 8'h03);
    wb(1'b1, IDX_CTRL_A, 8'hD7);
    repeat (20) @(posedge clk_i);
    wb(1'b1, IDX_CTRL_A, 8'h00);
    rd(IDX_CTRL_A, 8'h00);
    rd(IDX_IRQ_STATUS, 8'h02);
    chk({7'h0, conv.enable}, 8'h00);
    run(8'hD0, 50);
    wb(1'b1, IDX_TRIG_SEL, 8'h02);
    wb(1'b1, IDX_CTRL_A, 8'hB0);
    trig <= 8'h04;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (conv.start !== 1'b1 && n < 8);
    chk({7'h0, conv.start}, 8'h01);
    wait_done;
    trig <= 8'h00;
    wb(1'b1, IDX_TRIG_SEL, 8'h00);
    wb(1'b1, IDX_CTRL_A, 8'hF0);
    wait_done;
    repeat (2) @(posedge clk_i);
    rd(IDX_CTRL_A, 8'hF0);
    wb(1'b1, IDX_CTRL_A, 8'h80);
    end_sim;
  end
endmodule : adc_control_and_mux_select_tb
